// ==== shared/tase_defines.vh ====
// constants for the transfer and add/subtract execution unit
`ifndef TASE_DEFINES_VH
`define TASE_DEFINES_VH

// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define TASE_OP_COPY_A_R      4'h0
`define TASE_OP_COPY_R_A      4'h1
`define TASE_OP_COPY_A_HLD    4'h2
`define TASE_OP_COPY_HLD_A    4'h3
`define TASE_OP_WCOPY_AX_RP   4'h4
`define TASE_OP_WCOPY_RP_AX   4'h5
`define TASE_OP_WSWAP_AX_RP   4'h6
`define TASE_OP_SWAP_A_HLD    4'h7
`define TASE_OP_SWAP_A_R      4'h8
`define TASE_OP_SWAP_A_X      4'h9
`define TASE_OP_ADD_A_IMM     4'ha
`define TASE_OP_SUM_WITH_CARRY_INSTR_SD_IMM   4'hb
`define TASE_OP_ARITH_A_ABS   4'hc
`define TASE_OP_SUB_SD_IMM    4'hd
`define TASE_OP_SUM_WITH_CARRY_INSTR_A_HL     4'he
`define TASE_OP_FLAG_RESTORE  4'hf

// ----------------------------------------------------------------
// arithmetic selector for the absolute-operand form
// ----------------------------------------------------------------
`define TASE_FN_ADD   2'h0
`define TASE_FN_SUM_WITH_CARRY_INSTR  2'h1
`define TASE_FN_SUB   2'h2

// ----------------------------------------------------------------
// instruction lengths in bytes
// ----------------------------------------------------------------
`define TASE_LEN_1  2'h1
`define TASE_LEN_2  2'h2
`define TASE_LEN_3  2'h3

// ----------------------------------------------------------------
// execution times in instruction clocks
// ----------------------------------------------------------------
`define TASE_CLK_4  4'h4
`define TASE_CLK_6  4'h6
`define TASE_CLK_8  4'h8

// ----------------------------------------------------------------
// byte register codes and pair numbers
// ----------------------------------------------------------------
`define TASE_R_X   3'h0
`define TASE_R_A   3'h1
`define TASE_R_L   3'h6
`define TASE_R_H   3'h7
`define TASE_RP_AX 2'h0

// ----------------------------------------------------------------
// short direct window
// ----------------------------------------------------------------
`define TASE_SD_LO 16'hfe20
`define TASE_SD_HI 16'hff1f

`endif

// ==== rtl/tase_exec.v ====
// execution unit for byte/word moves, swaps and add/subtract instructions
`include "tase_defines.vh"

module tase_exec (
  // clock and reset
  input wire CLK_I,
  input wire RST_I,
  // cpu clock rate select: 0 full, 1 half, 2 quarter, 3 eighth
  input wire [1:0] CPU_CLK_SEL_I,
  // instruction request
  input wire START_I,
  input wire [3:0] OP_I,
  input wire [1:0] FUNC_I,
  input wire [2:0] REG_I,
  input wire [1:0] PAIR_I,
  input wire [7:0] IMM_I,
  input wire [15:0] ADDR_I,
  input wire FLAG_SAVE_I,
  output wire READY_O,
  output reg DONE_O,
  output reg ERR_O,
  output reg [1:0] LEN_O,
  // memory port, read data valid while the read strobe is high
  output reg [15:0] MEM_ADDR_O,
  output reg [7:0] MEM_WDATA_O,
  output reg MEM_RD_O,
  output reg MEM_WR_O,
  input wire [7:0] MEM_RDATA_I,
  // register state
  output wire [15:0] AX_O,
  output wire [15:0] BC_O,
  output wire [15:0] DE_O,
  output wire [15:0] HL_O,
  output wire ZERO_O,
  output wire HALF_CARRY_O,
  output wire CARRY_O
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function [1:0] op_len;
    input [3:0] op;
    begin
      case (op)
        `TASE_OP_WCOPY_AX_RP, `TASE_OP_WCOPY_RP_AX, `TASE_OP_WSWAP_AX_RP,
        `TASE_OP_SWAP_A_X, `TASE_OP_SUM_WITH_CARRY_INSTR_A_HL, `TASE_OP_FLAG_RESTORE: op_len = `TASE_LEN_1;
        `TASE_OP_SUM_WITH_CARRY_INSTR_SD_IMM, `TASE_OP_ARITH_A_ABS, `TASE_OP_SUB_SD_IMM: op_len = `TASE_LEN_3;
        default: op_len = `TASE_LEN_2;
      endcase
    end
  endfunction
  function [3:0] op_clocks;
    input [3:0] op;
    begin
      case (op)
        `TASE_OP_COPY_A_HLD, `TASE_OP_COPY_HLD_A: op_clocks = `TASE_CLK_6;
        `TASE_OP_WSWAP_AX_RP, `TASE_OP_SWAP_A_HLD: op_clocks = `TASE_CLK_8;
        `TASE_OP_SWAP_A_R: op_clocks = `TASE_CLK_6;
        `TASE_OP_SUM_WITH_CARRY_INSTR_SD_IMM, `TASE_OP_SUB_SD_IMM: op_clocks = `TASE_CLK_6;
        `TASE_OP_ARITH_A_ABS: op_clocks = `TASE_CLK_8;
        `TASE_OP_SUM_WITH_CARRY_INSTR_A_HL: op_clocks = `TASE_CLK_6;
        default: op_clocks = `TASE_CLK_4;
      endcase
    end
  endfunction
  function needs_read;
    input [3:0] op;
    begin
      needs_read = (op == `TASE_OP_COPY_A_HLD) || (op == `TASE_OP_SWAP_A_HLD) ||
                   (op == `TASE_OP_SUM_WITH_CARRY_INSTR_SD_IMM) || (op == `TASE_OP_SUB_SD_IMM) ||
                   (op == `TASE_OP_ARITH_A_ABS) || (op == `TASE_OP_SUM_WITH_CARRY_INSTR_A_HL);
    end
  endfunction
  // returns {carry, half carry, result}
  function [9:0] alu;
    input [7:0] a;
    input [7:0] b;
    input cin;
    input sub;
    reg [8:0] full;
    reg [4:0] low;
    begin
      if (sub) begin
        full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
      end else begin
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      end
      alu = {full[8], low[4], full[7:0]};
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [7:0] regs [0:7];
  reg z_r, ac_r, cy_r;
  reg z_sv_r, ac_sv_r, cy_sv_r;
  reg busy_r;
  reg [3:0] cnt_r;
  reg [3:0] op_r;
  reg [1:0] func_r;
  reg [2:0] reg_r;
  reg [1:0] pair_r;
  reg [7:0] imm_r;
  reg [15:0] ea_r;
  reg [7:0] mdr_r;
  reg [2:0] div_r;
  integer i;

  wire [7:0] acc = regs[`TASE_R_A];
  wire [15:0] hl = {regs[`TASE_R_H], regs[`TASE_R_L]};
  wire [2:0] lo_idx = {pair_r, 1'b0};
  wire [2:0] hi_idx = {pair_r, 1'b1};

  assign READY_O = ~busy_r;
  assign AX_O = {regs[`TASE_R_A], regs[`TASE_R_X]};
  assign BC_O = {regs[3], regs[2]};
  assign DE_O = {regs[5], regs[4]};
  assign HL_O = hl;
  assign ZERO_O = z_r;
  assign HALF_CARRY_O = ac_r;
  assign CARRY_O = cy_r;

  // ----------------------------------------------------------------
  // cpu clock divider
  // ----------------------------------------------------------------
  // a slower cpu clock only spaces out ticks; all logic stays on CLK_I
  reg [2:0] div_mask;
  always @* begin
    case (CPU_CLK_SEL_I)
      2'h0: div_mask = 3'h0;
      2'h1: div_mask = 3'h1;
      2'h2: div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  end
  wire tick = ((div_r & div_mask) == div_mask);

  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // request checking
  // ----------------------------------------------------------------
  wire sd_ok = (ADDR_I >= `TASE_SD_LO) && (ADDR_I <= `TASE_SD_HI);
  reg legal;
  reg [15:0] ea_nxt;
  always @* begin
    legal = 1'b1;
    ea_nxt = ADDR_I;
    case (OP_I)
      `TASE_OP_COPY_A_R, `TASE_OP_COPY_R_A: legal = (REG_I != `TASE_R_A);
      `TASE_OP_WCOPY_AX_RP, `TASE_OP_WCOPY_RP_AX,
      `TASE_OP_WSWAP_AX_RP: legal = (PAIR_I != `TASE_RP_AX);
      `TASE_OP_SWAP_A_R: legal = (REG_I != `TASE_R_A) && (REG_I != `TASE_R_X);
      `TASE_OP_SUM_WITH_CARRY_INSTR_SD_IMM, `TASE_OP_SUB_SD_IMM: legal = sd_ok;
      `TASE_OP_ARITH_A_ABS: legal = (FUNC_I != 2'h3);
      `TASE_OP_COPY_A_HLD, `TASE_OP_COPY_HLD_A,
      `TASE_OP_SWAP_A_HLD: ea_nxt = hl + {8'h00, IMM_I};
      `TASE_OP_SUM_WITH_CARRY_INSTR_A_HL: ea_nxt = hl;
      default: legal = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // result of the current operation
  // ----------------------------------------------------------------
  reg [9:0] res;
  always @* begin
    case (op_r)
      `TASE_OP_ADD_A_IMM: res = alu(acc, imm_r, 1'b0, 1'b0);
      `TASE_OP_SUM_WITH_CARRY_INSTR_SD_IMM: res = alu(mdr_r, imm_r, cy_r, 1'b0);
      `TASE_OP_SUB_SD_IMM: res = alu(mdr_r, imm_r, 1'b0, 1'b1);
      `TASE_OP_SUM_WITH_CARRY_INSTR_A_HL: res = alu(acc, mdr_r, cy_r, 1'b0);
      `TASE_OP_ARITH_A_ABS: res = alu(acc, mdr_r, (func_r == `TASE_FN_SUM_WITH_CARRY_INSTR) & cy_r,
                                     func_r == `TASE_FN_SUB);
      default: res = 10'h000;
    endcase
  end
  wire arith = (op_r == `TASE_OP_ADD_A_IMM) || (op_r == `TASE_OP_SUM_WITH_CARRY_INSTR_SD_IMM) ||
               (op_r == `TASE_OP_SUB_SD_IMM) || (op_r == `TASE_OP_SUM_WITH_CARRY_INSTR_A_HL) ||
               (op_r == `TASE_OP_ARITH_A_ABS);
  wire to_mem = (op_r == `TASE_OP_SUM_WITH_CARRY_INSTR_SD_IMM) || (op_r == `TASE_OP_SUB_SD_IMM);
  wire last = busy_r && tick && (cnt_r == 4'h1);

  // ----------------------------------------------------------------
  // sequencing, memory and register update
  // ----------------------------------------------------------------
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      for (i = 0; i < 8; i = i + 1) begin
        regs[i] <= 8'h00;
      end
      z_r <= 1'b0;
      ac_r <= 1'b0;
      cy_r <= 1'b0;
      z_sv_r <= 1'b0;
      ac_sv_r <= 1'b0;
      cy_sv_r <= 1'b0;
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      op_r <= 4'h0;
      func_r <= 2'h0;
      reg_r <= 3'h0;
      pair_r <= 2'h0;
      imm_r <= 8'h00;
      ea_r <= 16'h0000;
      mdr_r <= 8'h00;
      DONE_O <= 1'b0;
      ERR_O <= 1'b0;
      LEN_O <= 2'h0;
      MEM_ADDR_O <= 16'h0000;
      MEM_WDATA_O <= 8'h00;
      MEM_RD_O <= 1'b0;
      MEM_WR_O <= 1'b0;
    end else begin
      DONE_O <= 1'b0;
      ERR_O <= 1'b0;
      MEM_RD_O <= 1'b0;
      MEM_WR_O <= 1'b0;
      if (FLAG_SAVE_I) begin
        z_sv_r <= z_r;
        ac_sv_r <= ac_r;
        cy_sv_r <= cy_r;
      end
      if (MEM_RD_O) mdr_r <= MEM_RDATA_I;
      if (!busy_r && START_I) begin
        if (legal) begin
          busy_r <= 1'b1;
          cnt_r <= op_clocks(OP_I);
          LEN_O <= op_len(OP_I);
          op_r <= OP_I;
          func_r <= FUNC_I;
          reg_r <= REG_I;
          pair_r <= PAIR_I;
          imm_r <= IMM_I;
          ea_r <= ea_nxt;
        end else begin
          ERR_O <= 1'b1;
        end
      end
      if (busy_r && tick) begin
        cnt_r <= cnt_r - 4'h1;
        if (cnt_r == op_clocks(op_r) && needs_read(op_r)) begin
          MEM_RD_O <= 1'b1;
          MEM_ADDR_O <= ea_r;
        end
      end
      if (last) begin
        busy_r <= 1'b0;
        DONE_O <= 1'b1;
        case (op_r)
          `TASE_OP_COPY_A_R: regs[`TASE_R_A] <= regs[reg_r];
          `TASE_OP_COPY_R_A: regs[reg_r] <= acc;
          `TASE_OP_COPY_A_HLD: regs[`TASE_R_A] <= mdr_r;
          `TASE_OP_COPY_HLD_A: begin
            MEM_WR_O <= 1'b1;
            MEM_ADDR_O <= ea_r;
            MEM_WDATA_O <= acc;
          end
          `TASE_OP_WCOPY_AX_RP: begin
            regs[`TASE_R_X] <= regs[lo_idx];
            regs[`TASE_R_A] <= regs[hi_idx];
          end
          `TASE_OP_WCOPY_RP_AX: begin
            regs[lo_idx] <= regs[`TASE_R_X];
            regs[hi_idx] <= regs[`TASE_R_A];
          end
          `TASE_OP_WSWAP_AX_RP: begin
            {regs[`TASE_R_A], regs[`TASE_R_X]} <= {regs[hi_idx], regs[lo_idx]};
            {regs[hi_idx], regs[lo_idx]} <= AX_O;
          end
          `TASE_OP_SWAP_A_HLD: begin
            regs[`TASE_R_A] <= mdr_r;
            MEM_WR_O <= 1'b1;
            MEM_ADDR_O <= ea_r;
            MEM_WDATA_O <= acc;
          end
          `TASE_OP_SWAP_A_R: begin
            regs[`TASE_R_A] <= regs[reg_r];
            regs[reg_r] <= acc;
          end
          `TASE_OP_SWAP_A_X: begin
            regs[`TASE_R_A] <= regs[`TASE_R_X];
            regs[`TASE_R_X] <= acc;
          end
          `TASE_OP_FLAG_RESTORE: begin
            z_r <= z_sv_r;
            ac_r <= ac_sv_r;
            cy_r <= cy_sv_r;
          end
          default: begin
            if (to_mem) begin
              MEM_WR_O <= 1'b1;
              MEM_ADDR_O <= ea_r;
              MEM_WDATA_O <= res[7:0];
            end else begin
              regs[`TASE_R_A] <= res[7:0];
            end
          end
        endcase
        // moves and swaps leave every flag untouched
        if (arith) begin
          z_r <= (res[7:0] == 8'h00);
          ac_r <= res[8];
          cy_r <= res[9];
        end
      end
    end
  end

endmodule

// ==== verification/tase_mem_model.sv ====
// byte-wide program and data memory on the far side of the execution unit
module tase_mem_model (
  // clock
  input wire clk_i,
  // memory port
  input wire [15:0] addr_i,
  input wire [7:0] wdata_i,
  input wire rd_i,
  input wire wr_i,
  output wire [7:0] rdata_o
);
  // ----
  // storage
  // ----
  logic [7:0] mem [0:65535];
  logic [7:0] last_r = 8'h0;
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[7:0] ^ i[15:8];
    end
  end
  always @(posedge clk_i) begin
    if (rd_i) last_r <= mem[addr_i];
    if (wr_i) mem[addr_i] <= wdata_i;
  end
  // outside a read the bus shows the inverse of the last byte, so a late sample reads wrong
  assign rdata_o = rd_i ? mem[addr_i] : ~last_r;
endmodule

// ==== verification/tase_exec_monitor.sv ====
// assertion checker for the transfer and add/subtract execution unit
module tase_exec_chk (
  // clock, reset and request
  input wire CLK_I,
  input wire RST_I,
  input wire [1:0] CPU_CLK_SEL_I,
  input wire START_I,
  input wire [3:0] OP_I,
  input wire [1:0] FUNC_I,
  input wire [2:0] REG_I,
  input wire [1:0] PAIR_I,
  input wire [15:0] ADDR_I,
  input wire FLAG_SAVE_I,
  // results
  input wire READY_O,
  input wire DONE_O,
  input wire ERR_O,
  input wire [1:0] LEN_O,
  input wire [15:0] MEM_ADDR_O,
  input wire MEM_WR_O,
  input wire MEM_RD_O,
  input wire [15:0] AX_O,
  input wire ZERO_O,
  input wire HALF_CARRY_O,
  input wire CARRY_O
);
  // ----
  // helper state of the running instruction
  // ----
  localparam [63:0] LENS = 64'h1133321221112222;
  localparam [63:0] CLKS = 64'h4668644688446644;
  reg [3:0] op_r;
  reg [1:0] sel_r;
  reg [7:0] cnt_r;
  reg [2:0] sv_r;
  reg [15:0] ad_r;
  wire [2:0] flg = {ZERO_O, HALF_CARRY_O, CARRY_O};
  wire [7:0] nclk = {4'h0, CLKS[{op_r, 2'h0} +: 4]};
  // first tick waits up to one divider period, so the window is one period wide
  wire [7:0] hi = nclk << sel_r;
  wire [7:0] lo = (nclk - 8'h1) << sel_r;
  wire bad = (OP_I <= 4'h1 && REG_I == 3'h1) || (OP_I == 4'h8 && REG_I <= 3'h1)
    || (OP_I >= 4'h4 && OP_I <= 4'h6 && PAIR_I == 2'h0) || (OP_I == 4'hc && FUNC_I == 2'h3)
    || ((OP_I == 4'hb || OP_I == 4'hd) && (ADDR_I < 16'hfe20 || ADDR_I > 16'hff1f));
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      op_r <= 4'h0;
      sel_r <= 2'h0;
      cnt_r <= 8'h0;
      sv_r <= 3'h0;
      ad_r <= 16'h0;
    end else begin
      if (FLAG_SAVE_I) sv_r <= flg;
      if (START_I && READY_O) begin
        op_r <= OP_I;
        sel_r <= CPU_CLK_SEL_I;
        ad_r <= ADDR_I;
        cnt_r <= 8'h0;
      end else if (!READY_O) begin
        cnt_r <= cnt_r + 8'h1;
      end
    end
  end
  // ----
  // properties
  // ----
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_take; START_I && READY_O; endsequence
  sequence s_busy; !READY_O [*3]; endsequence
  AST_REFUSE: assert property (s_take ##0 bad |-> ##[1:2] ERR_O)
    else $error("illegal request not refused");
  AST_BUSY: assert property (s_take ##0 !bad |=> s_busy)
    else $error("unit not busy after accept");
  AST_TIME: assert property (DONE_O |-> cnt_r > lo && cnt_r <= hi)
    else $error("execution time off");
  AST_LEN: assert property (DONE_O |-> LEN_O == LENS[{op_r, 2'h0} +: 2])
    else $error("wrong instruction length");
  AST_ERR: assert property (ERR_O |-> !DONE_O && $stable(AX_O) && $stable(flg))
    else $error("refused request changed state");
  AST_KEEP: assert property (DONE_O && op_r <= 4'h9 |-> $stable(flg))
    else $error("transfer changed flags");
  AST_RESTORE: assert property (DONE_O && op_r == 4'hf |-> flg == sv_r)
    else $error("flags not restored");
  AST_SD_WRITE: assert property (DONE_O && (op_r == 4'hb || op_r == 4'hd) |->
    MEM_WR_O && MEM_ADDR_O == ad_r) else $error("short direct result not written");
  AST_WR_DONE: assert property (MEM_WR_O |-> DONE_O)
    else $error("write outside commit");
  AST_ZERO: assert property (DONE_O && (op_r == 4'ha || op_r == 4'he) |->
    ZERO_O == (AX_O[15:8] == 8'h0)) else $error("zero flag wrong");
  AST_PULSE: assert property (DONE_O |=> !DONE_O)
    else $error("done longer than one cycle");
  AST_READ: assert property (MEM_RD_O |-> !READY_O && !DONE_O &&
    (op_r < 4'hb || op_r > 4'hd || MEM_ADDR_O == ad_r))
    else $error("read strobe outside busy or at wrong address");
endmodule

bind tase_exec tase_exec_chk u_chk (
  .CLK_I(CLK_I), .RST_I(RST_I), .CPU_CLK_SEL_I(CPU_CLK_SEL_I), .START_I(START_I),
  .OP_I(OP_I), .FUNC_I(FUNC_I), .REG_I(REG_I), .PAIR_I(PAIR_I), .ADDR_I(ADDR_I),
  .FLAG_SAVE_I(FLAG_SAVE_I), .READY_O(READY_O), .DONE_O(DONE_O), .ERR_O(ERR_O),
  .LEN_O(LEN_O), .MEM_ADDR_O(MEM_ADDR_O), .MEM_WR_O(MEM_WR_O), .MEM_RD_O(MEM_RD_O),
  .AX_O(AX_O),
  .ZERO_O(ZERO_O), .HALF_CARRY_O(HALF_CARRY_O), .CARRY_O(CARRY_O));

// ==== verification/tb_tase_exec.sv ====
// self-checking bench for the transfer and add/subtract execution unit
module tb_tase_exec;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // signals and model state
  // ----
  localparam [63:0] LENS = 64'h1133321221112222;
  localparam [63:0] CLKS = 64'h4668644688446644;
  logic CLK_I = 1'b0;
  logic RST_I = 1'b1;
  logic [1:0] CPU_CLK_SEL_I = 2'h0;
  logic START_I = 1'b0;
  logic [3:0] OP_I = 4'h0;
  logic [1:0] FUNC_I = 2'h0;
  logic [2:0] REG_I = 3'h0;
  logic [1:0] PAIR_I = 2'h0;
  logic [7:0] IMM_I = 8'h0;
  logic [15:0] ADDR_I = 16'h0;
  logic FLAG_SAVE_I = 1'b0;
  wire READY_O, DONE_O, ERR_O, MEM_RD_O, MEM_WR_O, ZERO_O, HALF_CARRY_O, CARRY_O;
  wire [1:0] LEN_O;
  wire [15:0] MEM_ADDR_O, AX_O, BC_O, DE_O, HL_O;
  wire [7:0] MEM_WDATA_O, MEM_RDATA_I;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h46349d0f;
  int r[8];
  int mm[int];
  bit z, ac, cy, sz, sac, scy;
  always #2.5 CLK_I = ~CLK_I;
  tase_exec DUT (.CLK_I(CLK_I), .RST_I(RST_I), .CPU_CLK_SEL_I(CPU_CLK_SEL_I),
    .START_I(START_I), .OP_I(OP_I), .FUNC_I(FUNC_I), .REG_I(REG_I), .PAIR_I(PAIR_I),
    .IMM_I(IMM_I), .ADDR_I(ADDR_I), .FLAG_SAVE_I(FLAG_SAVE_I), .READY_O(READY_O),
    .DONE_O(DONE_O), .ERR_O(ERR_O), .LEN_O(LEN_O), .MEM_ADDR_O(MEM_ADDR_O),
    .MEM_WDATA_O(MEM_WDATA_O), .MEM_RD_O(MEM_RD_O), .MEM_WR_O(MEM_WR_O),
    .MEM_RDATA_I(MEM_RDATA_I), .AX_O(AX_O), .BC_O(BC_O), .DE_O(DE_O), .HL_O(HL_O),
    .ZERO_O(ZERO_O), .HALF_CARRY_O(HALF_CARRY_O), .CARRY_O(CARRY_O));
  tase_mem_model u_mem (.clk_i(CLK_I), .addr_i(MEM_ADDR_O), .wdata_i(MEM_WDATA_O),
    .rd_i(MEM_RD_O), .wr_i(MEM_WR_O), .rdata_o(MEM_RDATA_I));
  // ----
  // helpers
  // ----
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int rdm(int a);
    return mm.exists(a) ? mm[a] : ((a ^ (a >> 8)) & 255);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic finish_test();
    if (mismatches == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic sw(inout int a, inout int b);
    int t;
    t = a;
    a = b;
    b = t;
  endtask
  task automatic ar(input int x, input int y, input int c, input bit s, output int q);
    q = s ? x - y - c : x + y + c;
    ac = s ? (x & 15) < (y & 15) + c : (x & 15) + (y & 15) + c > 15;
    cy = q < 0 || q > 255;
    q = q & 255;
    z = q == 0;
  endtask
  // one instruction: model first, then drive, then compare at the result
  task automatic run(input int op, fn, rg, pr, im, ad, sel, input bit sv);
    int hl, ea, wa, wd, k;
    bit il, jk;
    hl = r[7] * 256 + r[6];
    ea = (hl + im) & 65535;
    wa = -1;
    wd = 0;
    il = 0;
    if (sv) {sz, sac, scy} = {z, ac, cy};
    case (op)
      0, 1, 8: il = rg == 1 || (op == 8 && rg == 0);
      4, 5, 6: il = pr == 0;
      11, 13: il = ad < 'hfe20 || ad > 'hff1f;
      12: il = fn == 3;
    endcase
    if (!il) case (op)
      0: r[1] = r[rg];
      1: r[rg] = r[1];
      2: r[1] = rdm(ea);
      3, 7: begin
        wa = ea;
        wd = r[1];
        if (op == 7) r[1] = rdm(ea);
      end
      4, 5, 6: begin
        if (op == 4) r[0] = r[2 * pr];
        if (op == 4) r[1] = r[2 * pr + 1];
        if (op == 5) r[2 * pr] = r[0];
        if (op == 5) r[2 * pr + 1] = r[1];
        if (op == 6) sw(r[0], r[2 * pr]);
        if (op == 6) sw(r[1], r[2 * pr + 1]);
      end
      8: sw(r[1], r[rg]);
      9: sw(r[1], r[0]);
      10: ar(r[1], im, 0, 0, r[1]);
      11, 13: begin
        ar(rdm(ad), im, op == 11 ? cy : 0, op == 13, wd);
        wa = ad;
      end
      12: ar(r[1], rdm(ad), fn == 1 ? cy : 0, fn == 2, r[1]);
      14: ar(r[1], rdm(hl), cy, 0, r[1]);
      15: {z, ac, cy} = {sz, sac, scy};
    endcase
    if (wa >= 0) mm[wa] = wd;
    jk = !il && rnd() % 2;
    @(posedge CLK_I);
    START_I <= 1'b1;
    OP_I <= op[3:0];
    FUNC_I <= fn[1:0];
    REG_I <= rg[2:0];
    PAIR_I <= pr[1:0];
    IMM_I <= im[7:0];
    ADDR_I <= ad[15:0];
    CPU_CLK_SEL_I <= sel[1:0];
    FLAG_SAVE_I <= sv;
    @(posedge CLK_I);
    START_I <= 1'b0;
    FLAG_SAVE_I <= 1'b0;
    k = 0;
    #1;
    // a stray request while busy must be ignored
    while (!DONE_O && !ERR_O && k < 80) begin
      @(posedge CLK_I);
      START_I <= jk && k == 1;
      k++;
      #1;
    end
    chk({DONE_O, ERR_O}, il ? 1 : 2, "outcome");
    if (!il) begin
      chk(k > ((CLKS[op * 4 +: 4] - 1) << sel) && k <= CLKS[op * 4 +: 4] << sel, 1, "time");
      chk(LEN_O, LENS[op * 4 +: 4], "length");
      chk(MEM_WR_O ? {1'b1, MEM_ADDR_O, MEM_WDATA_O} : 25'h0,
          wa < 0 ? 0 : 1 << 24 | wa << 8 | wd, "write");
    end
    chk({AX_O, BC_O}, r[1] << 24 | r[0] << 16 | r[3] << 8 | r[2], "ax bc");
    chk({DE_O, HL_O}, r[5] << 24 | r[4] << 16 | r[7] << 8 | r[6], "de hl");
    chk({ZERO_O, HALF_CARRY_O, CARRY_O}, {z, ac, cy}, "flags");
    while (!READY_O && k < 99) begin
      @(posedge CLK_I);
      k++;
      #1;
    end
  endtask
  // ----
  // main sequence and hang limit
  // ----
  always @(posedge CLK_I) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    logic [31:0] x;
    int ad;
    repeat (10) @(posedge CLK_I);
    RST_I <= 1'b0;
    // first 64 cover every op with every function code
    for (int i = 0; i < 600; i++) begin
      x = rnd();
      ad = x[31:29] < 4 ? (x[29] ? 'hff1f : 'hfe1f) + x[30] : 'hfe20 + x[28:21];
      run(i < 64 ? i % 16 : x[3:0], i < 64 ? i / 16 : x[5:4], x[8:6], x[10:9], x[23:16],
          ad, x[12:11], x[13]);
    end
    finish_test();
  end
endmodule
